/* File: src/uabc_top.v */
`include "uabc_regs.vh"
`default_nettype none
module uabc_top #(
  parameter DIV_W = 16
) (
  input wire clock,
  input wire nrst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire rx_pin,
  input wire lin_packet_start,
  input wire break_seen,
  input wire tx_byte_done,
  input wire [7:0] tx_byte,
  input wire rx_byte_done,
  input wire [7:0] rx_byte,
  input wire byte_is_pid,
  output reg [DIV_W-1:0] baud_divisor_pair,
  output wire uart_hold_idle,
  output wire receive_line_idle_status
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function [7:0] sum8;
    input [7:0] a;
    input [7:0] b;
    begin
      sum8 = a + b;
    end
  endfunction

  function addr_hit;
    input [11:0] a;
    input [11:0] match;
    begin
      addr_hit = (a == match);
    end
  endfunction

  // lin keeps the pid out unless checksum mode is set; other modes need the mode
  function byte_counts;
    input lin;
    input csum_mode;
    input pid;
    begin
      byte_counts = lin ? (csum_mode | ~pid) : csum_mode;
    end
  endfunction

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  wire wr_en;
  wire rd_sel;
  wire known;
  // zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;
  assign rd_sel = psel & ~pwrite;
  assign known = addr_hit(paddr, `UABC_CTRL_ADDR) | addr_hit(paddr, `UABC_STAT_ADDR) |
    addr_hit(paddr, `UABC_DIV_ADDR) | addr_hit(paddr, `UABC_TXSUM_ADDR) |
    addr_hit(paddr, `UABC_RXSUM_ADDR);
  // unmapped addresses answer with an error, writes there are dropped
  assign pslverr = psel & penable & ~known;

  reg autobaud_enable_bit;
  reg baud_high_speed_select;
  reg wake_on_break_enable;
  reg checksum_mode_select;
  reg [1:0] mode_reg;
  reg autobaud_done_flag;
  reg [7:0] transmit_byte_sum;
  reg [7:0] receive_byte_sum;

  // ----------------------------------------
  // receive pin synchroniser
  // ----------------------------------------
  reg [2:0] rx_sync_reg;
  reg rx_level_reg;
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rx_sync_reg <= 3'h7;
      rx_level_reg <= 1'b1;
    end else begin
      rx_sync_reg <= {rx_sync_reg[1:0], rx_pin};
      if (rx_sync_reg[1] == rx_sync_reg[2])
        rx_level_reg <= rx_sync_reg[2];
    end
  end
  wire rx_agree;
  wire rx_fall;
  wire rx_rise;
  // a change counts only once flops two and three agree, so a one-cycle glitch is lost
  assign rx_agree = (rx_sync_reg[1] == rx_sync_reg[2]);
  assign rx_fall = rx_level_reg & rx_agree & ~rx_sync_reg[2];
  assign rx_rise = ~rx_level_reg & rx_agree & rx_sync_reg[2];

  // ----------------------------------------
  // detection state machine
  // ----------------------------------------
  localparam [3:0] S_IDLE = 4'b0001;
  localparam [3:0] S_BREAK = 4'b0010;
  localparam [3:0] S_ARMED = 4'b0100;
  localparam [3:0] S_COUNT = 4'b1000;

  reg [3:0] state_reg;
  reg [3:0] state_next;
  reg [2:0] falls_reg;
  reg [2:0] rises_reg;
  reg [DIV_W-1:0] baud_generator;
  reg sync_active_reg;
  reg lin_armed_reg;

  wire is_lin;
  wire is_async8;
  wire start_req;
  assign is_lin = (mode_reg == `UABC_MODE_LIN);
  assign is_async8 = (mode_reg == `UABC_MODE_ASYNC8);
  // software enable only counts in 8-bit async; lin starts on its own
  assign start_req = (is_async8 & autobaud_enable_bit) | (is_lin & lin_armed_reg);

  // ----------------------------------------
  // baud measurement
  // ----------------------------------------
  wire det_tick;
  wire tick_run;
  wire [7:0] ratio;
  // detection clock = base clock / 8: fosc/32 or fosc/128
  assign ratio = baud_high_speed_select ? (`UABC_BASE_DIV_HS * `UABC_DET_RATIO) :
    (`UABC_BASE_DIV_LS * `UABC_DET_RATIO);
  // the divider starts on the first fall itself, so the first period is not cut short
  assign tick_run = (state_reg == S_COUNT) | ((state_reg == S_ARMED) & rx_fall);

  uabc_tick #(.W(8)) u_tick (
    .clock(clock),
    .nrst(nrst),
    .run(tick_run),
    .ratio(ratio),
    .tick(det_tick)
  );

  wire fifth_fall;
  assign fifth_fall = (state_reg == S_COUNT) & rx_fall &
    (falls_reg == `UABC_SYNC_FALLS - 3'h1);

  // armed waits for the first fall; a dropped request abandons the wait
  always @* begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE: begin
        if (start_req)
          state_next = (wake_on_break_enable & ~is_lin) ? S_BREAK : S_ARMED;
      end
      S_BREAK: begin
        if (!start_req)
          state_next = S_IDLE;
        else if (break_seen)
          state_next = S_ARMED;
      end
      S_ARMED: begin
        if (!start_req)
          state_next = S_IDLE;
        else if (rx_fall)
          state_next = S_COUNT;
      end
      S_COUNT: begin
        if (fifth_fall)
          state_next = S_IDLE;
      end
      default: state_next = S_IDLE;
    endcase
  end

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_reg <= S_IDLE;
      falls_reg <= 3'h0;
      baud_generator <= {DIV_W{1'b0}};
      baud_divisor_pair <= `UABC_DIV_RESET;
      lin_armed_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      // leaving lin mode drops a packet start that never got its sync byte
      if (is_lin & lin_packet_start)
        lin_armed_reg <= 1'b1;
      else if (fifth_fall | ~is_lin)
        lin_armed_reg <= 1'b0;
      if (state_reg == S_ARMED && rx_fall) begin
        falls_reg <= 3'h1;
        baud_generator <= {DIV_W{1'b0}};
      end else if (state_reg == S_COUNT) begin
        if (rx_fall)
          falls_reg <= falls_reg + 3'h1;
        if (det_tick)
          baud_generator <= baud_generator + {{(DIV_W-1){1'b0}}, 1'b1};
      end
      // visible divisor only changes on a completed measurement or a write while idle; the tick that lands
      // on the fifth fall closes the last period, so it is added in here
      if (fifth_fall)
        baud_divisor_pair <= baud_generator + {{(DIV_W-1){1'b0}}, det_tick};
      else if (wr_en && addr_hit(paddr, `UABC_DIV_ADDR) && state_reg == S_IDLE)
        baud_divisor_pair <= pwdata[DIV_W-1:0];
    end
  end

  // sync-in-progress window: first fall to fifth rise
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sync_active_reg <= 1'b0;
      rises_reg <= 3'h0;
    end else if (state_reg == S_ARMED && rx_fall) begin
      sync_active_reg <= 1'b1;
      rises_reg <= 3'h0;
    end else if (sync_active_reg && rx_rise) begin
      rises_reg <= rises_reg + 3'h1;
      if (rises_reg == `UABC_SYNC_RISES - 3'h1)
        sync_active_reg <= 1'b0;
    end
  end
  assign receive_line_idle_status = ~sync_active_reg;
  assign uart_hold_idle = (state_reg != S_IDLE) | sync_active_reg;

  // ----------------------------------------
  // control and checksum registers
  // ----------------------------------------
  wire ctrl_wr;
  wire stat_wr;
  wire tx_take;
  wire rx_take;
  assign ctrl_wr = wr_en & addr_hit(paddr, `UABC_CTRL_ADDR);
  assign stat_wr = wr_en & addr_hit(paddr, `UABC_STAT_ADDR);
  assign tx_take = tx_byte_done & byte_counts(is_lin, checksum_mode_select, byte_is_pid);
  assign rx_take = rx_byte_done & byte_counts(is_lin, checksum_mode_select, byte_is_pid);

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      autobaud_enable_bit <= 1'b0;
      baud_high_speed_select <= 1'b0;
      wake_on_break_enable <= 1'b0;
      checksum_mode_select <= 1'b0;
      mode_reg <= `UABC_MODE_ASYNC8;
      autobaud_done_flag <= 1'b0;
      transmit_byte_sum <= `UABC_SUM_RESET;
      receive_byte_sum <= `UABC_SUM_RESET;
    end else begin
      if (ctrl_wr) begin
        baud_high_speed_select <= pwdata[`UABC_CTRL_HS];
        wake_on_break_enable <= pwdata[`UABC_CTRL_WAKE];
        checksum_mode_select <= pwdata[`UABC_CTRL_CSUM];
        mode_reg <= pwdata[`UABC_CTRL_MODE_HI:`UABC_CTRL_MODE_LO];
      end
      // hardware clear on completion wins over a software write
      if (fifth_fall)
        autobaud_enable_bit <= 1'b0;
      else if (ctrl_wr)
        autobaud_enable_bit <= pwdata[`UABC_CTRL_AB_EN];
      // set beats clear; write one to clear
      if (fifth_fall)
        autobaud_done_flag <= 1'b1;
      else if (stat_wr && pwdata[`UABC_STAT_DONE])
        autobaud_done_flag <= 1'b0;
      if (wr_en && addr_hit(paddr, `UABC_TXSUM_ADDR))
        transmit_byte_sum <= pwdata[7:0];
      else if (tx_take)
        transmit_byte_sum <= sum8(transmit_byte_sum, tx_byte);
      if (wr_en && addr_hit(paddr, `UABC_RXSUM_ADDR))
        receive_byte_sum <= pwdata[7:0];
      else if (rx_take)
        receive_byte_sum <= sum8(receive_byte_sum, rx_byte);
    end
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      prdata <= 32'h00000000;
    end else if (rd_sel && !penable) begin
      prdata <= 32'h00000000;
      if (addr_hit(paddr, `UABC_CTRL_ADDR))
        prdata[5:0] <= {mode_reg, checksum_mode_select, wake_on_break_enable,
          baud_high_speed_select, autobaud_enable_bit};
      else if (addr_hit(paddr, `UABC_STAT_ADDR))
        prdata[2:0] <= {(state_reg != S_IDLE), receive_line_idle_status,
          autobaud_done_flag};
      else if (addr_hit(paddr, `UABC_DIV_ADDR))
        prdata[DIV_W-1:0] <= baud_divisor_pair;
      else if (addr_hit(paddr, `UABC_TXSUM_ADDR))
        prdata[7:0] <= transmit_byte_sum;
      else if (addr_hit(paddr, `UABC_RXSUM_ADDR))
        prdata[7:0] <= receive_byte_sum;
    end
  end
endmodule
`default_nettype wire

/* File: include/uabc_regs.vh */
`ifndef UABC_REGS_VH
`define UABC_REGS_VH
// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define UABC_CTRL_ADDR 12'h000
`define UABC_STAT_ADDR 12'h004
`define UABC_DIV_ADDR 12'h008
`define UABC_TXSUM_ADDR 12'h00C
`define UABC_RXSUM_ADDR 12'h010
// ----------------------------------------
// control fields
// ----------------------------------------
`define UABC_CTRL_AB_EN 0
`define UABC_CTRL_HS 1
`define UABC_CTRL_WAKE 2
`define UABC_CTRL_CSUM 3
`define UABC_CTRL_MODE_LO 4
`define UABC_CTRL_MODE_HI 5
// modes: 0 async 8-bit, 1 async 7/9-bit, 2 lin
`define UABC_MODE_ASYNC8 2'h0
`define UABC_MODE_OTHER 2'h1
`define UABC_MODE_LIN 2'h2
// status fields
`define UABC_STAT_DONE 0
`define UABC_STAT_IDLE 1
`define UABC_STAT_BUSY 2
// ----------------------------------------
// reset values and clock ratios
// ----------------------------------------
`define UABC_DIV_RESET 16'h0000
`define UABC_SUM_RESET 8'h00
`define UABC_BASE_DIV_HS 8'h04
`define UABC_BASE_DIV_LS 8'h10
`define UABC_DET_RATIO 8'h08
`define UABC_SYNC_FALLS 3'h5
`define UABC_SYNC_RISES 3'h5
`endif

/* File: src/uabc_tick.v */
`default_nettype none
// divides the system clock by a run-time ratio into a one-cycle tick
module uabc_tick #(
  parameter W = 8
) (
  input wire clock,
  input wire nrst,
  input wire run,
  input wire [W-1:0] ratio,
  output reg tick
);
  reg [W-1:0] cnt_reg;
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= {W{1'b0}};
      tick <= 1'b0;
    end else if (!run) begin
      cnt_reg <= {W{1'b0}};
      tick <= 1'b0;
    end else if (cnt_reg >= ratio - {{(W-1){1'b0}}, 1'b1}) begin
      cnt_reg <= {W{1'b0}};
      tick <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + {{(W-1){1'b0}}, 1'b1};
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: sim/uabc_top_properties.sv */
`default_nettype none
module uabc_checker (
  input wire logic clock,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [15:0] baud_divisor_pair,
  input wire logic uart_hold_idle,
  input wire logic receive_line_idle_status
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  logic mapped;
  assign mapped = paddr inside {12'h000, 12'h004, 12'h008, 12'h00C, 12'h010};
  sequence s_read;
    psel && !penable && !pwrite ##1 psel && penable;
  endsequence
  property p_ready; pready; endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  property p_unmapped; psel && penable && !mapped |-> pslverr; endproperty
  a_unmapped: assert property (p_unmapped) else $error("no error on unmapped");
  property p_err_access; pslverr |-> psel && penable; endproperty
  a_err_access: assert property (p_err_access) else $error("error outside access");
  property p_rd_hold; s_read ##1 !psel |=> $stable(prdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_hold; !receive_line_idle_status |-> uart_hold_idle; endproperty
  a_hold: assert property (p_hold) else $error("uart not held idle");
  property p_armed; $fell(receive_line_idle_status) |-> $past(uart_hold_idle); endproperty
  a_armed: assert property (p_armed) else $error("sync without enable");
  property p_div_src;
    $changed(baud_divisor_pair) |-> $past(!receive_line_idle_status) ||
      $past(psel && penable && pwrite && paddr == 12'h008);
  endproperty
  a_div_src: assert property (p_div_src) else $error("divisor changed early");
  property p_sync; $fell(receive_line_idle_status) |-> !receive_line_idle_status [*8]; endproperty
  a_sync: assert property (p_sync) else $error("sync window too short");
endmodule
bind uabc_top uabc_checker uabc_checker_inst (.clock(clock), .nrst(nrst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .baud_divisor_pair(baud_divisor_pair), .uart_hold_idle(uart_hold_idle),
  .receive_line_idle_status(receive_line_idle_status));
`default_nettype wire

/* File: sim/uabc_node.sv */
`default_nettype none
module uabc_node (
  input wire logic clock,
  input wire logic go,
  input wire logic [15:0] bit_cycles,
  output logic rx_line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] frame;
  // one process owns the line; it idles high between frames
  initial begin
    rx_line = 1'b1;
    forever begin
      @(posedge clock);
      if (go) begin
        // bit time chosen so the detection clock can measure it
        frame = {1'b1, 8'h55, 1'b0};
        for (int i = 0; i < 10; i++) begin
          rx_line <= frame[i];
          repeat (bit_cycles) @(posedge clock);
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: sim/uart_autobaud_checksum_tb_top.sv */
`default_nettype none
module uart_autobaud_checksum_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] q; logic e;} uabc_row_t;
  logic clock = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic go = 0, tdone = 0, rdone = 0, pid = 0, rx_pin, pready, pslverr;
  logic lps = 0, brk = 0, sawlow;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [7:0] bv = 8'h00;
  logic [15:0] div;
  wire hold, idle;
  int errors = 0, check_count = 0;
  uabc_row_t rows [4] = '{'{12'h00C, 32'h1A5, 32'hA5, 1'b0}, '{12'h010, 32'hFFFFFF3C, 32'h3C, 1'b0},
    '{12'h008, 32'h1234, 32'h1234, 1'b0}, '{12'h020, 32'hFF, 32'h0, 1'b1}};
  always #4 clock = ~clock;
  uabc_top uabc_top_inst (.clock(clock), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_pin(rx_pin), .lin_packet_start(lps), .break_seen(brk),
    .tx_byte_done(tdone), .tx_byte(bv), .rx_byte_done(rdone), .rx_byte(bv), .byte_is_pid(pid),
    .baud_divisor_pair(div), .uart_hold_idle(hold), .receive_line_idle_status(idle));
  uabc_node uabc_node_inst (.clock(clock), .go(go), .bit_cycles(16'h0100), .rx_line(rx_pin));
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic send(input logic tx, input logic [7:0] b, input logic is_pid);
    @(posedge clock);
    tdone <= tx;
    rdone <= !tx;
    bv <= b;
    pid <= is_pid;
    @(posedge clock);
    tdone <= 1'b0;
    rdone <= 1'b0;
    pid <= 1'b0;
  endtask
  task automatic sync_frame(output logic low_seen);
    @(posedge clock);
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    low_seen = 1'b0;
    // long enough for all ten bits of the node's frame to pass
    repeat (2700) begin
      @(posedge clock);
      if (idle === 1'b0) low_seen = 1'b1;
    end
  endtask
  initial begin
    #400us;
    errors++;
    stop_test();
  end
  initial begin
    repeat (6) @(posedge clock);
    nrst <= 1'b1;
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].d);
      check("write error", err, rows[i].e);
      apb(1'b0, rows[i].a, 32'h0);
      check("read data", rd, rows[i].q);
      check("read error", err, rows[i].e);
    end
    $display("register rows done");
    apb(1'b1, 12'h000, 32'h18);
    apb(1'b1, 12'h00C, 32'hF0);
    send(1'b1, 8'h20, 1'b0);
    send(1'b0, 8'h11, 1'b0);
    apb(1'b0, 12'h00C, 32'h0);
    check("tx sum wrap", rd, 32'h10);
    apb(1'b0, 12'h010, 32'h0);
    check("rx sum", rd, 32'h4D);
    apb(1'b1, 12'h000, 32'h20);
    apb(1'b1, 12'h010, 32'h0);
    send(1'b0, 8'h80, 1'b1);
    send(1'b0, 8'h05, 1'b0);
    apb(1'b0, 12'h010, 32'h0);
    check("lin rx sum no id", rd, 32'h05);
    apb(1'b1, 12'h000, 32'h28);
    send(1'b1, 8'h80, 1'b1);
    apb(1'b0, 12'h00C, 32'h0);
    check("lin tx sum with id", rd, 32'h90);
    $display("checksum tests done");
    apb(1'b1, 12'h000, 32'h03);
    @(posedge clock);
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    repeat (400) if (idle !== 1'b0) @(posedge clock);
    check("idle in sync", idle, 1'b0);
    check("hold in sync", hold, 1'b1);
    apb(1'b0, 12'h008, 32'h0);
    check("divisor kept", rd, 32'h1234);
    repeat (3000) if (idle !== 1'b1) @(posedge clock);
    apb(1'b0, 12'h008, 32'h0);
    // eight bits of 256 cycles counted at one tick per 32 cycles
    check("divisor measured", rd, 32'h00000040);
    check("divisor port", {16'h0000, div}, 32'h00000040);
    apb(1'b0, 12'h000, 32'h0);
    check("enable cleared", rd[0], 1'b0);
    repeat (100) @(posedge clock);
    apb(1'b0, 12'h004, 32'h0);
    check("done flag", rd[1:0], 2'h3);
    apb(1'b1, 12'h004, 32'h1);
    apb(1'b0, 12'h004, 32'h0);
    check("done cleared", rd[0], 1'b0);
    $display("autobaud test done");
    @(posedge clock);
    nrst <= 1'b0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    check("divisor reset", {16'h0000, div}, 32'h00000000);
    check("hold reset", hold, 1'b0);
    check("idle reset", idle, 1'b1);
    apb(1'b0, 12'h00C, 32'h0);
    check("tx sum reset", rd, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    check("rx sum reset", rd, 32'h0);
    $display("reset test done");
    // let the node finish the stop bit of the earlier frame
    repeat (300) @(posedge clock);
    apb(1'b1, 12'h000, 32'h13);
    sync_frame(sawlow);
    check("sync in other mode", sawlow, 1'b0);
    apb(1'b0, 12'h004, 32'h0);
    check("no done in other mode", rd[0], 1'b0);
    apb(1'b1, 12'h000, 32'h05);
    sync_frame(sawlow);
    check("sync before break", sawlow, 1'b0);
    @(posedge clock);
    brk <= 1'b1;
    @(posedge clock);
    brk <= 1'b0;
    sync_frame(sawlow);
    check("sync after break", sawlow, 1'b1);
    apb(1'b0, 12'h008, 32'h0);
    // slow select: 256 cycles per bit over a fosc/16 base clock
    check("divisor slow clock", rd, 32'h00000010);
    $display("mode and break tests done");
    apb(1'b1, 12'h004, 32'h1);
    apb(1'b1, 12'h000, 32'h22);
    sync_frame(sawlow);
    check("lin sync unarmed", sawlow, 1'b0);
    @(posedge clock);
    lps <= 1'b1;
    @(posedge clock);
    lps <= 1'b0;
    sync_frame(sawlow);
    check("lin sync armed", sawlow, 1'b1);
    apb(1'b0, 12'h008, 32'h0);
    check("lin divisor", rd, 32'h00000040);
    apb(1'b0, 12'h004, 32'h0);
    check("lin done flag", rd[0], 1'b1);
    $display("lin test done");
    stop_test();
  end
endmodule
`default_nettype wire
